/* src/mrtc_consts.svh */
// constants for the multiplexed-bus real time clock
`ifndef MRTC_CONSTS_SVH
`define MRTC_CONSTS_SVH
// time, calendar and alarm byte offsets
`define MRTC_IX_SEC     0
`define MRTC_IX_SEC_AL  1
`define MRTC_IX_MIN     2
`define MRTC_IX_MIN_AL  3
`define MRTC_IX_HR      4
`define MRTC_IX_HR_AL   5
`define MRTC_IX_WDAY    6
`define MRTC_IX_MDAY    7
`define MRTC_IX_MON     8
`define MRTC_IX_YEAR    9
`define MRTC_TIME_BYTES 10
// control registers and user ram
`define MRTC_REG_A      7'h0a
`define MRTC_REG_B      7'h0b
`define MRTC_REG_C      7'h0c
`define MRTC_REG_D      7'h0d
`define MRTC_RAM_BASE   7'h0e
`define MRTC_RAM_BYTES  114
`define MRTC_REG_D_VAL  8'h80
`define MRTC_OSC_RST    3'b000
`define MRTC_OSC_RUN    3'b010
`define MRTC_DONT_CARE  2'b11
// calendar limits, binary form
`define MRTC_SEC_MAX    8'h3b
`define MRTC_HR_MAX     8'h17
`define MRTC_HR12       8'h0c
`define MRTC_WDAY_MAX   8'h07
`define MRTC_MON_MAX    8'h0c
`define MRTC_YEAR_MAX   8'h63
`define MRTC_DIM_LONG   8'h1f
`define MRTC_DIM_SHORT  8'h1e
`define MRTC_DIM_LEAP   8'h1d
`define MRTC_DIM_FEB    8'h1c
// timing
`define MRTC_CLK_HZ     100000000
`define MRTC_UPD_S      1
`define MRTC_FIRST_MS   500
`define MRTC_UIP_US     244
`endif

/* src/mrtc_pkg.sv */
// types shared by the real time clock modules
package mrtc_pkg;
  typedef enum logic [1:0] {
    MRTC_OSC_STOP = 2'b00,
    MRTC_OSC_GO   = 2'b01,
    MRTC_OSC_HOLD = 2'b10
  } mrtc_osc_t;
endpackage

/* src/mrtc_user_ram.sv */
// general purpose user ram with registered read and clear-to-ones
`timescale 1ns/1ps
`default_nettype none
`include "mrtc_consts.svh"
module mrtc_user_ram
  import mrtc_pkg::*;
#(
  parameter int DEPTH = `MRTC_RAM_BYTES,
  parameter int W     = 8,
  parameter int AW    = 7
)(
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  input  wire logic          clear_in,
  input  wire logic          we_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [W-1:0]  wdata_in,
  input  wire logic [AW-1:0] raddr_in,
  output logic      [W-1:0]  rdata_out
);
  logic [W-1:0] mem [0:DEPTH-1];

  // one process per byte; clear beats a write
  for (genvar e = 0; e < DEPTH; e++) begin : g_byte
    always_ff @(posedge clk_in)
    begin
      if (clear_in)
        mem[e] <= '1;
      else if (we_in && waddr_in == AW'(e))
        mem[e] <= wdata_in;
    end
  end

  // read every cycle, no dependence on update activity
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      rdata_out <= '0;
    else if (raddr_in < AW'(DEPTH))
      rdata_out <= mem[raddr_in];
    else
      rdata_out <= '0;
  end
endmodule // mrtc_user_ram
`default_nettype wire

/* src/mrtc_time_step.sv */
// one-second advance of time and calendar in binary or bcd
`timescale 1ns/1ps
`default_nettype none
`include "mrtc_consts.svh"
module mrtc_time_step
  import mrtc_pkg::*;
(
  input  wire logic       bin_in,
  input  wire logic       h24_in,
  input  wire logic [7:0] sec_in,
  input  wire logic [7:0] min_in,
  input  wire logic [7:0] hr_in,
  input  wire logic [7:0] wday_in,
  input  wire logic [7:0] mday_in,
  input  wire logic [7:0] mon_in,
  input  wire logic [7:0] year_in,
  output logic      [7:0] sec_out,
  output logic      [7:0] min_out,
  output logic      [7:0] hr_out,
  output logic      [7:0] wday_out,
  output logic      [7:0] mday_out,
  output logic      [7:0] mon_out,
  output logic      [7:0] year_out
);
  function automatic logic [7:0] to_bin(input logic [7:0] v,
                                        input logic b);
    return b ? v : {4'h0, v[7:4]} * 8'h0a + {4'h0, v[3:0]};
  endfunction

  function automatic logic [7:0] to_fmt(input logic [7:0] v,
                                        input logic b);
    logic [7:0] t;
    t = v / 8'h0a;
    return b ? v : {t[3:0], 4'(v - t * 8'h0a)};
  endfunction

  // work in binary, convert back at the end
  always_comb
  begin
    logic [7:0] s, m, hb, hv, hm, hf, w, d, mo, y, dim;
    logic       cs, cm, ch, cd, cmo;
    s   = to_bin({1'b0, sec_in[6:0]}, bin_in);
    m   = to_bin(min_in, bin_in);
    w   = to_bin(wday_in, bin_in);
    d   = to_bin(mday_in, bin_in);
    mo  = to_bin(mon_in, bin_in);
    y   = to_bin(year_in, bin_in);
    hb  = to_bin({h24_in & hr_in[7], hr_in[6:0]}, bin_in);
    // fold 12-hour codes onto 0..23, top bit marks pm
    hv  = hb;
    if (!h24_in)
      hv = ((hb == `MRTC_HR12) ? 8'h00 : hb)
         + (hr_in[7] ? `MRTC_HR12 : 8'h00);
    // leap years are those divisible by four
    case (mo)
      8'h02:   dim = (y[1:0] == 2'b00) ? `MRTC_DIM_LEAP : `MRTC_DIM_FEB;
      8'h04, 8'h06, 8'h09, 8'h0b: dim = `MRTC_DIM_SHORT;
      default: dim = `MRTC_DIM_LONG;
    endcase
    cs  = (s >= `MRTC_SEC_MAX);
    cm  = cs && (m >= `MRTC_SEC_MAX);
    ch  = cm && (hv >= `MRTC_HR_MAX);
    cd  = ch && (d >= dim);
    cmo = cd && (mo >= `MRTC_MON_MAX);
    s   = cs ? 8'h00 : s + 8'h01;
    if (cs)
      m = cm ? 8'h00 : m + 8'h01;
    if (cm)
      hv = ch ? 8'h00 : hv + 8'h01;
    if (ch)
      w = (w >= `MRTC_WDAY_MAX) ? 8'h01 : w + 8'h01;
    if (ch)
      d = cd ? 8'h01 : d + 8'h01;
    if (cd)
      mo = cmo ? 8'h01 : mo + 8'h01;
    if (cmo)
      y = (y >= `MRTC_YEAR_MAX) ? 8'h00 : y + 8'h01;
    hm = (hv >= `MRTC_HR12) ? hv - `MRTC_HR12 : hv;
    if (hm == 8'h00)
      hm = `MRTC_HR12;
    sec_out  = to_fmt(s, bin_in);
    min_out  = to_fmt(m, bin_in);
    wday_out = to_fmt(w, bin_in);
    mday_out = to_fmt(d, bin_in);
    mon_out  = to_fmt(mo, bin_in);
    year_out = to_fmt(y, bin_in);
    // a call result cannot be part-selected, so park it first
    hf       = to_fmt(hm, bin_in);
    hr_out   = h24_in ? to_fmt(hv, bin_in)
             : {hv >= `MRTC_HR12, hf[6:0]};
  end
endmodule // mrtc_time_step
`default_nettype wire

/* src/mrtc_top.sv */
// real time clock with user ram behind a multiplexed address/data bus
`timescale 1ns/1ps
`default_nettype none
`include "mrtc_consts.svh"
module mrtc_top
  import mrtc_pkg::*;
#(
  parameter int CYC_PER_SEC = `MRTC_UPD_S * `MRTC_CLK_HZ
)(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] shared_addr_data_bus_in,
  output logic      [7:0] shared_addr_data_bus_out,
  output logic            shared_addr_data_bus_oe_n_out,
  input  wire logic       address_latch_strobe_in,
  input  wire logic       read_strobe_pin_n_in,
  input  wire logic       write_strobe_n_in,
  input  wire logic       chip_select_n_in,
  input  wire logic       user_ram_clear_n_in,
  output logic            irq_n_out,
  output logic            irq_oe_n_out
);
  // pin positions in the synchroniser vector
  localparam int CI_AS  = 0;
  localparam int CI_RD  = 1;
  localparam int CI_WR  = 2;
  localparam int CI_CS  = 3;
  localparam int CI_CLR = 4;
  localparam logic [4:0] CTL_IDLE = 5'h1e;

  // derived cycle counts; shortened runs clamp to one cycle
  localparam int DW        = $clog2(CYC_PER_SEC + 1);
  localparam int FIRST_RAW = (CYC_PER_SEC / 1000) * `MRTC_FIRST_MS;
  localparam int FIRST_CYC = (FIRST_RAW < 1) ? 1 : FIRST_RAW;
  localparam int UIP_RAW   = (CYC_PER_SEC / 1000000) * `MRTC_UIP_US;
  localparam int UIP_CYC   = (UIP_RAW < 1) ? 1 : UIP_RAW;
  localparam logic [DW-1:0] DIV_LAST  = DW'(CYC_PER_SEC - 1);
  localparam logic [DW-1:0] DIV_START = DW'(CYC_PER_SEC - FIRST_CYC);
  localparam logic [DW-1:0] DIV_HALF  = DW'(FIRST_CYC - 1);
  localparam logic [DW-1:0] DIV_UIP   = DW'(CYC_PER_SEC - UIP_CYC);

  // synchronisers and edge history
  logic [4:0]    ctl_s1;
  logic [4:0]    ctl_s2;
  logic [4:0]    ctl_d;
  logic [7:0]    bus_s1;
  logic [7:0]    bus_s2;
  // bus cycle state
  logic [6:0]    addr;
  logic          as_fall;
  logic          rd_fall;
  logic          rd_rise;
  logic          wr_rise;
  logic          sel;
  logic          wr_ev;
  logic          rd_ev;
  logic [7:0]    wdat;
  logic [7:0]    rdat;
  logic          is_time;
  logic          is_ram;
  logic [6:0]    ram_ix;
  logic [7:0]    ram_q;
  // control registers
  logic [2:0]    osc;
  logic [3:0]    rate;
  logic          freeze;
  logic          per_ie;
  logic          alm_ie;
  logic          upd_ie;
  logic          sqw_en;
  logic          binary_format_select;
  logic          h24;
  logic          dst_en;
  logic          uip;
  mrtc_osc_t     osc_mode;
  // divider and events
  logic [DW-1:0] div;
  logic          tick;
  logic          per_ev;
  logic          alm_match;
  logic [2:0]    ev;
  logic [2:0]    flg;
  logic [2:0]    held;
  logic          c_busy;
  logic          irq_on;
  // time bytes: internal copy and host-visible copy
  logic [7:0]    ti [0:`MRTC_TIME_BYTES-1];
  logic [7:0]    tu [0:`MRTC_TIME_BYTES-1];
  logic [7:0]    nx [0:`MRTC_TIME_BYTES-1];

  // two flops on every pin before any logic looks at it
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ctl_s1 <= CTL_IDLE;
      ctl_s2 <= CTL_IDLE;
      ctl_d  <= CTL_IDLE;
      bus_s1 <= 8'h00;
      bus_s2 <= 8'h00;
    end
    else
    begin
      ctl_s1 <= {user_ram_clear_n_in, chip_select_n_in,
                 write_strobe_n_in, read_strobe_pin_n_in,
                 address_latch_strobe_in};
      ctl_s2 <= ctl_s1;
      ctl_d  <= ctl_s2;
      bus_s1 <= shared_addr_data_bus_in;
      bus_s2 <= bus_s1;
    end
  end

  // edge events from the second stage only
  assign as_fall = ctl_d[CI_AS] & ~ctl_s2[CI_AS];
  assign rd_fall = ctl_d[CI_RD] & ~ctl_s2[CI_RD];
  assign rd_rise = ~ctl_d[CI_RD] & ctl_s2[CI_RD];
  assign wr_rise = ~ctl_d[CI_WR] & ctl_s2[CI_WR];
  // select is judged at the strobe edge itself
  assign sel     = ~ctl_s2[CI_CS];
  assign wr_ev   = wr_rise & sel;
  assign rd_ev   = rd_fall & sel;
  // data sampled at the closing edge of the write strobe
  assign wdat    = bus_s2;

  // address is latched whether or not the part is selected
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      addr <= 7'h00;
    else if (as_fall)
      addr <= bus_s2[6:0];
  end

  // map: ten time bytes, four control registers, user ram
  assign is_time = (addr < 7'(`MRTC_TIME_BYTES));
  assign is_ram  = (addr >= `MRTC_RAM_BASE);
  assign ram_ix  = addr - `MRTC_RAM_BASE;

  mrtc_user_ram #(
    .DEPTH (`MRTC_RAM_BYTES),
    .W     (8),
    .AW    (7)
  ) u_ram (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .clear_in  (~ctl_s2[CI_CLR]),
    .we_in     (wr_ev & is_ram),
    .waddr_in  (ram_ix),
    .wdata_in  (wdat),
    .raddr_in  (ram_ix),
    .rdata_out (ram_q)
  );

  // oscillator field decode
  always_comb
  begin
    case (osc)
      `MRTC_OSC_RUN: osc_mode = MRTC_OSC_GO;
      3'b110:        osc_mode = MRTC_OSC_HOLD;
      3'b111:        osc_mode = MRTC_OSC_HOLD;
      default:       osc_mode = MRTC_OSC_STOP;
    endcase
  end

  // register a: oscillator field and rate select; bit 7 read-only
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      osc  <= `MRTC_OSC_RST;
      rate <= 4'h0;
    end
    else if (wr_ev && addr == `MRTC_REG_A)
    begin
      osc  <= wdat[6:4];
      rate <= wdat[3:0];
    end
  end

  // register b; freeze rising drops the update-ended enable
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      freeze               <= 1'b0;
      per_ie               <= 1'b0;
      alm_ie               <= 1'b0;
      upd_ie               <= 1'b0;
      sqw_en               <= 1'b0;
      binary_format_select <= 1'b0;
      h24                  <= 1'b0;
      dst_en               <= 1'b0;
    end
    else if (wr_ev && addr == `MRTC_REG_B)
    begin
      freeze               <= wdat[7];
      per_ie               <= wdat[6];
      alm_ie               <= wdat[5];
      upd_ie               <= wdat[4] & ~(wdat[7] & ~freeze);
      sqw_en               <= wdat[3];
      binary_format_select <= wdat[2];
      h24                  <= wdat[1];
      dst_en               <= wdat[0];
    end
  end

  // divider chain; starting it lands the first tick half a second on
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      div <= '0;
    else if (wr_ev && addr == `MRTC_REG_A && wdat[6:4] == `MRTC_OSC_RUN
             && osc != `MRTC_OSC_RUN)
      div <= DIV_START;
    else if (osc_mode == MRTC_OSC_HOLD)
      div <= '0;
    else if (osc_mode == MRTC_OSC_GO)
      div <= (div == DIV_LAST) ? '0 : div + 1'b1;
  end

  // the final divider stage gives the once-a-second tick
  assign tick   = (osc_mode == MRTC_OSC_GO) && (div == DIV_LAST);
  // periodic event at half-second steps for any nonzero rate
  assign per_ev = (osc_mode == MRTC_OSC_GO) && (rate != 4'h0)
                && (div == DIV_HALF || div == DIV_LAST);

  // update-in-progress window just ahead of the tick, masked by freeze
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      uip <= 1'b0;
    else
      uip <= (osc_mode == MRTC_OSC_GO) && !freeze && (div >= DIV_UIP);
  end

  // next value of every time byte; alarms pass unchanged
  mrtc_time_step u_step (
    .bin_in   (binary_format_select),
    .h24_in   (h24),
    .sec_in   (ti[`MRTC_IX_SEC]),
    .min_in   (ti[`MRTC_IX_MIN]),
    .hr_in    (ti[`MRTC_IX_HR]),
    .wday_in  (ti[`MRTC_IX_WDAY]),
    .mday_in  (ti[`MRTC_IX_MDAY]),
    .mon_in   (ti[`MRTC_IX_MON]),
    .year_in  (ti[`MRTC_IX_YEAR]),
    .sec_out  (nx[`MRTC_IX_SEC]),
    .min_out  (nx[`MRTC_IX_MIN]),
    .hr_out   (nx[`MRTC_IX_HR]),
    .wday_out (nx[`MRTC_IX_WDAY]),
    .mday_out (nx[`MRTC_IX_MDAY]),
    .mon_out  (nx[`MRTC_IX_MON]),
    .year_out (nx[`MRTC_IX_YEAR])
  );
  assign nx[`MRTC_IX_SEC_AL] = ti[`MRTC_IX_SEC_AL];
  assign nx[`MRTC_IX_MIN_AL] = ti[`MRTC_IX_MIN_AL];
  assign nx[`MRTC_IX_HR_AL]  = ti[`MRTC_IX_HR_AL];

  // one process per time byte; host write wins over the tick
  for (genvar i = 0; i < `MRTC_TIME_BYTES; i++) begin : g_time
    localparam logic [7:0] WMASK = (i == `MRTC_IX_SEC) ? 8'h7f : 8'hff;
    always_ff @(posedge clk_in)
    begin
      if (rst_in)
      begin
        ti[i] <= 8'h00;
        tu[i] <= 8'h00;
      end
      else if (wr_ev && addr == 7'(i))
      begin
        ti[i] <= wdat & WMASK;
        tu[i] <= wdat & WMASK;
      end
      else if (tick)
      begin
        ti[i] <= nx[i];
        if (!freeze)
          tu[i] <= nx[i];
      end
    end
  end

  // alarm compare on the freshly advanced time
  function automatic logic hit(input logic [7:0] al,
                               input logic [7:0] t);
    return (al[7:6] == `MRTC_DONT_CARE) || (al == t);
  endfunction
  assign alm_match = hit(ti[`MRTC_IX_SEC_AL], nx[`MRTC_IX_SEC])
                   && hit(ti[`MRTC_IX_MIN_AL], nx[`MRTC_IX_MIN])
                   && hit(ti[`MRTC_IX_HR_AL], nx[`MRTC_IX_HR]);
  // events: periodic, alarm, update ended
  assign ev = {per_ev, tick & alm_match, tick};

  // status flags; a read clears them and parks events until it ends
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      flg    <= 3'b000;
      held   <= 3'b000;
      c_busy <= 1'b0;
    end
    else if (rd_ev && addr == `MRTC_REG_C)
    begin
      flg    <= 3'b000;
      held   <= ev; // same-cycle event is kept, not lost
      c_busy <= 1'b1;
    end
    else if (c_busy && rd_rise)
    begin
      flg    <= held | ev;
      held   <= 3'b000;
      c_busy <= 1'b0;
    end
    else if (c_busy)
      held <= held | ev;
    else
      flg <= flg | ev;
  end

  // interrupt drive follows flag and enable at once
  assign irq_on = |(flg & {per_ie, alm_ie, upd_ie});

  // open-drain pin: only ever pulls low
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      irq_n_out    <= 1'b0;
      irq_oe_n_out <= 1'b1;
    end
    else
    begin
      irq_n_out    <= 1'b0;
      irq_oe_n_out <= ~irq_on;
    end
  end

  // read data select
  always_comb
  begin
    if (is_time)
      rdat = tu[addr[3:0]];
    else if (addr == `MRTC_REG_A)
      rdat = {uip, osc, rate};
    else if (addr == `MRTC_REG_B)
      rdat = {freeze, per_ie, alm_ie, upd_ie,
              sqw_en, binary_format_select, h24, dst_en};
    else if (addr == `MRTC_REG_C)
      rdat = {~irq_oe_n_out, flg, 4'h0};
    else if (addr == `MRTC_REG_D)
      rdat = `MRTC_REG_D_VAL;
    else
      rdat = ram_q;
  end

  // drive the bus from the read strobe fall until it rises
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      shared_addr_data_bus_out      <= 8'h00;
      shared_addr_data_bus_oe_n_out <= 1'b1;
    end
    else if (rd_ev)
    begin
      shared_addr_data_bus_out      <= rdat;
      shared_addr_data_bus_oe_n_out <= 1'b0;
    end
    else if (rd_rise)
      shared_addr_data_bus_oe_n_out <= 1'b1;
  end
endmodule // mrtc_top
`default_nettype wire

/* verification/mrtc_top_properties.sv */
// concurrent checks on the bus and interrupt pins of the clock
`timescale 1ns/1ps
`default_nettype none
module mrtc_top_properties
  import mrtc_pkg::*;
#(
  parameter int CYC_PER_SEC = 2000
)(
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic [7:0] shared_addr_data_bus_in,
  input wire logic [7:0] shared_addr_data_bus_out,
  input wire logic       shared_addr_data_bus_oe_n_out,
  input wire logic       address_latch_strobe_in,
  input wire logic       read_strobe_pin_n_in,
  input wire logic       write_strobe_n_in,
  input wire logic       chip_select_n_in,
  input wire logic       user_ram_clear_n_in,
  input wire logic       irq_n_out,
  input wire logic       irq_oe_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // selected read gets the bus within a few cycles
  property p_answer;
    $fell(read_strobe_pin_n_in) && !chip_select_n_in
      |-> ##[2:6] !shared_addr_data_bus_oe_n_out;
  endproperty
  a_answer: assert property (p_answer)
    else $error("read strobe not answered");
  // drive holds while strobe stays low
  property p_stands;
    !shared_addr_data_bus_oe_n_out && !read_strobe_pin_n_in
      |=> !shared_addr_data_bus_oe_n_out;
  endproperty
  a_stands: assert property (p_stands)
    else $error("bus released during read");
  // no drive long after strobe went high
  property p_release;
    read_strobe_pin_n_in [*6] |-> shared_addr_data_bus_oe_n_out;
  endproperty
  a_release: assert property (p_release)
    else $error("bus still driven after read");
  // read byte stable while driven
  property p_stable;
    !shared_addr_data_bus_oe_n_out ##1 !shared_addr_data_bus_oe_n_out
      |-> $stable(shared_addr_data_bus_out);
  endproperty
  a_stable: assert property (p_stable)
    else $error("read byte changed during read");
  // deselected cycles never drive the bus
  property p_deselect;
    chip_select_n_in [*8] |-> shared_addr_data_bus_oe_n_out;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("bus driven while deselected");
  // open drain: only ever pulls low
  property p_od;
    !irq_oe_n_out |-> !irq_n_out;
  endproperty
  a_od: assert property (p_od)
    else $error("interrupt pin driven high");
  // pending interrupt only drops through a bus access
  property p_hold;
    (read_strobe_pin_n_in && write_strobe_n_in) [*8] ##0 !irq_oe_n_out
      |=> !irq_oe_n_out;
  endproperty
  a_hold: assert property (p_hold)
    else $error("interrupt dropped without access");
  // both pins float right after reset
  property p_reset;
    $fell(rst_in) |-> irq_oe_n_out && shared_addr_data_bus_oe_n_out;
  endproperty
  a_reset: assert property (p_reset)
    else $error("pins driven after reset");
endmodule // mrtc_top_properties
`default_nettype wire

/* verification/mrtc_host.sv */
// host processor model driving the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module mrtc_host (
  input  wire logic       clk_in,
  input  wire logic [7:0] bus_in,
  output logic      [7:0] ad_out,
  output logic            as_out,
  output logic            rd_n_out,
  output logic            wr_n_out,
  output logic            cs_n_out
);
  // idle bus at time zero
  initial
  begin
    ad_out = 8'h00;
    as_out = 1'b0;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    cs_n_out = 1'b1;
  end
  // one bus cycle; sel low leaves the device deselected
  task automatic cycle(input logic rd, input logic sel,
                       input logic [6:0] a, input logic [7:0] d,
                       output logic [7:0] q);
    @(posedge clk_in);
    as_out <= 1'b1;
    ad_out <= {1'b0, a};
    repeat (3) @(posedge clk_in);
    as_out <= 1'b0;
    repeat (3) @(posedge clk_in);
    cs_n_out <= ~sel;
    ad_out <= rd ? ~ad_out : d; // released lines wander, no pull-up
    @(posedge clk_in);
    rd_n_out <= ~rd;
    wr_n_out <= rd;
    repeat (12) @(posedge clk_in);
    q = bus_in;
    rd_n_out <= 1'b1;
    wr_n_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    cs_n_out <= 1'b1;
    ad_out <= ~ad_out;
  endtask
endmodule // mrtc_host
`default_nettype wire

/* verification/tb.sv */
// self-checking bench for the multiplexed-bus real time clock
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mrtc_pkg::*;
  logic       clk_in;
  logic       rst_in;
  logic       clr_n;
  logic [7:0] host_ad;
  logic       as_s;
  logic       rd_n;
  logic       wr_n;
  logic       cs_n;
  logic [7:0] dev_ad;
  logic       dev_oe_n;
  logic       irq_d;
  logic       irq_oe_n;
  logic [7:0] junk_q;
  int         failures;
  int         n_tests;
  wire logic [7:0] bus = dev_oe_n ? host_ad : dev_ad;
  wire logic       irq = irq_oe_n ? 1'b1 : irq_d; // pull-up

  mrtc_top #(.CYC_PER_SEC(2000)) u_mrtc_top (
    .clk_in(clk_in), .rst_in(rst_in),
    .shared_addr_data_bus_in(bus),
    .shared_addr_data_bus_out(dev_ad),
    .shared_addr_data_bus_oe_n_out(dev_oe_n),
    .address_latch_strobe_in(as_s), .read_strobe_pin_n_in(rd_n),
    .write_strobe_n_in(wr_n), .chip_select_n_in(cs_n),
    .user_ram_clear_n_in(clr_n), .irq_n_out(irq_d),
    .irq_oe_n_out(irq_oe_n)
  );
  mrtc_host u_mrtc_host (
    .clk_in(clk_in), .bus_in(bus), .ad_out(host_ad), .as_out(as_s),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .cs_n_out(cs_n)
  );

  // compare and count
  task automatic cmp(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_mrtc_host.cycle(1'b0, 1'b1, a, d, q);
  endtask
  task automatic chk(input string n, input logic [6:0] a,
                     input logic [7:0] e);
    logic [7:0] q;
    u_mrtc_host.cycle(1'b1, 1'b1, a, 8'h00, q);
    cmp(n, e, q);
  endtask
  // wait, bounded, for the interrupt pin to go low
  task automatic tick(input int lim);
    int i;
    for (i = 0; i < lim && irq !== 1'b0; i++)
      @(posedge clk_in);
    cmp("irq", 8'h00, {7'h00, irq});
  endtask
  task automatic conclude();
    $display("comparisons %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // 100 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // hang guard, far beyond the few ticks used
  initial
  begin
    repeat (30000) @(posedge clk_in);
    failures++;
    conclude();
  end
  // main sequence
  initial
  begin
    failures = 0;
    n_tests = 0;
    rst_in = 1'b1;
    clr_n = 1'b1;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    cmp("irq", 8'h01, {7'h00, irq});
    chk("reg_a", 7'h0a, 8'h00);
    chk("reg_d", 7'h0d, 8'h80);
    wr(7'h0e, 8'h5a);
    wr(7'h7f, 8'ha5);
    u_mrtc_host.cycle(1'b0, 1'b0, 7'h0e, 8'h11, junk_q);
    chk("ram_lo", 7'h0e, 8'h5a);
    chk("ram_hi", 7'h7f, 8'ha5);
    wr(7'h0c, 8'hff);
    wr(7'h0d, 8'h00);
    wr(7'h00, 8'hff);
    wr(7'h0a, 8'hff);
    chk("reg_c", 7'h0c, 8'h00);
    chk("reg_d", 7'h0d, 8'h80);
    chk("sec", 7'h00, 8'h7f);
    chk("reg_a", 7'h0a, 8'h7f);
    // ram clear leaves the time bytes alone
    clr_n <= 1'b0;
    repeat (5) @(posedge clk_in);
    clr_n <= 1'b1;
    chk("ram_lo", 7'h0e, 8'hff);
    chk("ram_hi", 7'h7f, 8'hff);
    chk("sec", 7'h00, 8'h7f);
    // binary 24 h rollover with all alarms don't care
    wr(7'h0b, 8'h16);
    wr(7'h00, 8'h3b);
    wr(7'h02, 8'h3b);
    wr(7'h04, 8'h17);
    wr(7'h01, 8'hff);
    wr(7'h03, 8'hc0);
    wr(7'h05, 8'hff);
    wr(7'h0a, 8'h20);
    repeat (900) @(posedge clk_in);
    cmp("irq", 8'h01, {7'h00, irq});
    tick(200);
    chk("reg_c", 7'h0c, 8'hb0);
    chk("sec", 7'h00, 8'h00);
    chk("min", 7'h02, 8'h00);
    chk("hr", 7'h04, 8'h00);
    chk("reg_c", 7'h0c, 8'h00);
    repeat (3) @(posedge clk_in);
    cmp("irq", 8'h01, {7'h00, irq});
    // bcd counting
    wr(7'h0b, 8'h12);
    wr(7'h00, 8'h09);
    tick(2100);
    chk("reg_c", 7'h0c, 8'hb0);
    chk("sec", 7'h00, 8'h10);
    // freeze drops the update enable and stops the user copy
    wr(7'h0b, 8'h92);
    chk("reg_b", 7'h0b, 8'h82);
    repeat (2100) @(posedge clk_in);
    chk("sec", 7'h00, 8'h10);
    chk("reg_c", 7'h0c, 8'h30);
    repeat (2100) @(posedge clk_in);
    wr(7'h0b, 8'h22);
    repeat (3) @(posedge clk_in);
    cmp("irq", 8'h00, {7'h00, irq});
    chk("reg_c", 7'h0c, 8'hb0);
    // bcd 12-hour: 11:59:59 pm rolls to 12 am; periodic flag polled
    wr(7'h0b, 8'h20);
    wr(7'h0a, 8'h2f);
    wr(7'h04, 8'h91);
    wr(7'h02, 8'h59);
    wr(7'h00, 8'h59);
    tick(2100);
    chk("hr12", 7'h04, 8'h12);
    chk("min12", 7'h02, 8'h00);
    chk("reg_c", 7'h0c, 8'hf0);
    conclude();
  end
endmodule // tb

bind mrtc_top mrtc_top_properties #(.CYC_PER_SEC(CYC_PER_SEC)) u_chk (
  .clk_in(clk_in), .rst_in(rst_in),
  .shared_addr_data_bus_in(shared_addr_data_bus_in),
  .shared_addr_data_bus_out(shared_addr_data_bus_out),
  .shared_addr_data_bus_oe_n_out(shared_addr_data_bus_oe_n_out),
  .address_latch_strobe_in(address_latch_strobe_in),
  .read_strobe_pin_n_in(read_strobe_pin_n_in),
  .write_strobe_n_in(write_strobe_n_in),
  .chip_select_n_in(chip_select_n_in),
  .user_ram_clear_n_in(user_ram_clear_n_in),
  .irq_n_out(irq_n_out), .irq_oe_n_out(irq_oe_n_out)
);
`default_nettype wire
